//--- pkg/sbh_pkg.sv
package sbh_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DAT_W     = 32;
	localparam int SEL_W     = 4;
	localparam int ADR_W     = 8;
	localparam int TAG_W     = 1;
	localparam int MEM_DEPTH = 16;
	localparam int IDX_W     = 4;
	localparam int LANE_W    = 8;
	localparam int CNT_W     = 5;
	localparam int RTY_W     = 3;
	localparam int STAT_W    = 8;

	// ----------------------------------------------------------------
	// Address layout
	// ----------------------------------------------------------------
	localparam int IDX_LSB = 2;
	localparam int HI_LSB  = IDX_LSB + IDX_W;

	// ----------------------------------------------------------------
	// Timing and reset values
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RTY_WAIT_NS   = 200;
	localparam int RTY_WAIT_CYC  = (RTY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [CNT_W-1:0]  RTY_WAIT_LOAD = CNT_W'(RTY_WAIT_CYC - 1);
	localparam logic [RTY_W-1:0]  RETRY_LIMIT   = 3'h3;
	localparam logic [CNT_W-1:0]  CNT_RST       = 5'h00;
	localparam logic [RTY_W-1:0]  RTY_RST       = 3'h0;
	localparam logic [STAT_W-1:0] STAT_RST      = 8'h00;
	localparam logic [DAT_W-1:0]  DAT_RST       = 32'h0000_0000;
	localparam logic [ADR_W-1:0]  ADR_RST       = 8'h00;
	localparam logic [SEL_W-1:0]  SEL_RST       = 4'h0;

	typedef enum logic [1:0] {
		MST_IDLE,
		MST_STROBE,
		MST_HOLD,
		MST_BACKOFF
	} sbh_mst_state_t;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic sbh_adr_hit(input logic [ADR_W-1:0] adr);
		sbh_adr_hit = (adr[ADR_W-1:HI_LSB] == '0);
	endfunction : sbh_adr_hit

	function automatic logic [IDX_W-1:0] sbh_word_idx(input logic [ADR_W-1:0] adr);
		sbh_word_idx = adr[HI_LSB-1:IDX_LSB];
	endfunction : sbh_word_idx

endpackage : sbh_pkg

//--- design/sbh_slv_term.sv
`timescale 1ns/100ps
module sbh_slv_term
	import sbh_pkg::*;
(
	input  wire logic sel_i,
	input  wire logic bad_adr,
	input  wire logic busy,
	output logic      ack,
	output logic      err,
	output logic      rty
);

	// ----------------------------------------------------------------
	// Terminator choice
	// ----------------------------------------------------------------
	// Pure gates from strobe: one transfer per clock, no wait state
	always_comb begin
		ack = 1'b0;
		err = 1'b0;
		rty = 1'b0;
		if (sel_i) begin
			if (bad_adr) begin
				err = 1'b1;
			end else if (busy) begin
				rty = 1'b1;
			end else begin
				ack = 1'b1;
			end
		end
	end

endmodule : sbh_slv_term

//--- design/sbh_lane_mux.sv
`timescale 1ns/100ps
module sbh_lane_mux
	import sbh_pkg::*;
(
	input  wire logic [DAT_W-1:0] base,
	input  wire logic [DAT_W-1:0] fresh,
	input  wire logic [SEL_W-1:0] sel,
	output logic      [DAT_W-1:0] merged
);

	// ----------------------------------------------------------------
	// Per byte lane pick
	// ----------------------------------------------------------------
	for (genvar g = 0; g < SEL_W; g++) begin : g_lane
		assign merged[g*LANE_W +: LANE_W] = sel[g] ? fresh[g*LANE_W +: LANE_W]
		                                           : base[g*LANE_W +: LANE_W];
	end

endmodule : sbh_lane_mux

//--- design/sbh_bus_node.sv
`timescale 1ns/100ps
module sbh_bus_node
	import sbh_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_we,
	input  wire logic [ADR_W-1:0]  req_adr,
	input  wire logic [DAT_W-1:0]  req_dat,
	input  wire logic [SEL_W-1:0]  req_sel,
	input  wire logic [TAG_W-1:0]  req_tag,
	input  wire logic              req_last,
	output logic                   rsp_valid,
	output logic      [DAT_W-1:0]  rsp_dat,
	output logic      [TAG_W-1:0]  rsp_tag,
	output logic                   rsp_err,
	output logic                   rsp_rty,
	output logic                   m_cyc_o,
	output logic                   m_stb_o,
	output logic                   m_we_o,
	output logic      [ADR_W-1:0]  m_adr_o,
	output logic      [DAT_W-1:0]  m_dat_o,
	output logic      [SEL_W-1:0]  m_sel_o,
	output logic      [TAG_W-1:0]  m_tag_o,
	input  wire logic              m_ack_i,
	input  wire logic              m_err_i,
	input  wire logic              m_rty_i,
	input  wire logic [DAT_W-1:0]  m_dat_i,
	input  wire logic [TAG_W-1:0]  m_tag_i,
	input  wire logic              s_cyc_i,
	input  wire logic              s_stb_i,
	input  wire logic              s_we_i,
	input  wire logic [ADR_W-1:0]  s_adr_i,
	input  wire logic [DAT_W-1:0]  s_dat_i,
	input  wire logic [SEL_W-1:0]  s_sel_i,
	output logic                   s_ack_o,
	output logic                   s_err_o,
	output logic                   s_rty_o,
	output logic      [DAT_W-1:0]  s_dat_o,
	output logic      [TAG_W-1:0]  s_tag_o,
	input  wire logic              slv_busy,
	output logic                   slv_wr_pulse,
	output logic      [STAT_W-1:0] slv_xfer_cnt,
	output logic      [STAT_W-1:0] slv_fault_cnt,
	output logic                   mst_busy
);

	// ----------------------------------------------------------------
	// Master declarations
	// ----------------------------------------------------------------
	sbh_mst_state_t    state_q;
	sbh_mst_state_t    state_d;
	logic              cyc_q;
	logic              stb_q;
	logic              we_q;
	logic [ADR_W-1:0]  adr_q;
	logic [DAT_W-1:0]  dat_q;
	logic [SEL_W-1:0]  sel_q;
	logic [TAG_W-1:0]  tag_q;
	logic              last_q;
	logic [RTY_W-1:0]  rty_cnt_q;
	logic [CNT_W-1:0]  wait_q;
	logic              rsp_valid_q;
	logic [DAT_W-1:0]  rsp_dat_q;
	logic [TAG_W-1:0]  rsp_tag_q;
	logic              rsp_err_q;
	logic              rsp_rty_q;
	logic              accept;
	logic              strobing;
	logic              got_ack;
	logic              got_err;
	logic              got_rty;
	logic              rty_give_up;

	// ----------------------------------------------------------------
	// Slave declarations
	// ----------------------------------------------------------------
	logic [DAT_W-1:0]  mem_q [MEM_DEPTH];
	logic [IDX_W-1:0]  s_idx;
	logic              s_sel;
	logic              s_hit;
	logic [DAT_W-1:0]  wr_word;
	logic [DAT_W-1:0]  rd_word;
	logic              slv_wr_pulse_q;
	logic [STAT_W-1:0] xfer_cnt_q;
	logic [STAT_W-1:0] fault_cnt_q;

	// ----------------------------------------------------------------
	// Master terminator decode
	// ----------------------------------------------------------------
	// Several terminators at once is a slave fault; error outranks
	// retry, retry outranks acknowledge, so nothing is lost silently.
	assign strobing    = (state_q == MST_STROBE);
	assign got_err     = strobing & m_err_i;
	assign got_rty     = strobing & ~m_err_i & m_rty_i;
	assign got_ack     = strobing & ~m_err_i & ~m_rty_i & m_ack_i;
	assign rty_give_up = (rty_cnt_q == RETRY_LIMIT);
	assign req_ready   = (state_q == MST_IDLE) | (state_q == MST_HOLD);
	assign accept      = req_valid & req_ready;

	// ----------------------------------------------------------------
	// Master sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			MST_IDLE: begin
				if (req_valid) begin
					state_d = MST_STROBE;
				end
			end
			MST_STROBE: begin
				if (got_err) begin
					state_d = MST_IDLE;
				end else if (got_rty) begin
					state_d = rty_give_up ? MST_IDLE : MST_BACKOFF;
				end else if (got_ack) begin
					state_d = last_q ? MST_IDLE : MST_HOLD;
				end
			end
			MST_HOLD: begin
				if (req_valid) begin
					state_d = MST_STROBE;
				end
			end
			MST_BACKOFF: begin
				if (wait_q == CNT_RST) begin
					state_d = MST_STROBE;
				end
			end
			default: begin
				state_d = MST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_q <= MST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Strobe and cycle flops
	// ----------------------------------------------------------------
	// Both follow the next state so they leave the flop with no gate
	// behind it; cycle spans a whole block except while backing off after
	// a retry, strobe only one transfer.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cyc_q <= 1'b0;
			stb_q <= 1'b0;
		end else begin
			cyc_q <= (state_d == MST_STROBE) | (state_d == MST_HOLD);
			stb_q <= (state_d == MST_STROBE);
		end
	end

	assign m_cyc_o = cyc_q;
	assign m_stb_o = stb_q;

	// ----------------------------------------------------------------
	// Master address phase
	// ----------------------------------------------------------------
	// Captured on acceptance and held through retries, so the
	// reissued strobe repeats the same request exactly.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			we_q   <= 1'b0;
			adr_q  <= ADR_RST;
			dat_q  <= DAT_RST;
			sel_q  <= SEL_RST;
			tag_q  <= '0;
			last_q <= 1'b1;
		end else if (accept) begin
			we_q   <= req_we;
			adr_q  <= req_adr;
			dat_q  <= req_dat;
			sel_q  <= req_sel;
			tag_q  <= req_tag;
			last_q <= req_last;
		end
	end

	assign m_we_o  = we_q;
	assign m_adr_o = adr_q;
	assign m_dat_o = dat_q;
	assign m_sel_o = sel_q;
	assign m_tag_o = tag_q;

	// ----------------------------------------------------------------
	// Retry bookkeeping
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rty_cnt_q <= RTY_RST;
		end else if (accept) begin
			rty_cnt_q <= RTY_RST;
		end else if (got_rty & ~rty_give_up) begin
			rty_cnt_q <= rty_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wait_q <= CNT_RST;
		end else if (got_rty) begin
			wait_q <= RTY_WAIT_LOAD;
		end else if ((state_q == MST_BACKOFF) & (wait_q != CNT_RST)) begin
			wait_q <= wait_q - 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Master answer to the user
	// ----------------------------------------------------------------
	// Retries below the limit stay invisible to the user.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rsp_valid_q <= 1'b0;
			rsp_err_q   <= 1'b0;
			rsp_rty_q   <= 1'b0;
		end else begin
			rsp_valid_q <= got_ack | got_err | (got_rty & rty_give_up);
			rsp_err_q   <= got_err;
			rsp_rty_q   <= got_rty & rty_give_up;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rsp_dat_q <= DAT_RST;
			rsp_tag_q <= '0;
		end else if (got_ack) begin
			rsp_dat_q <= we_q ? DAT_RST : m_dat_i;
			rsp_tag_q <= m_tag_i;
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp_dat   = rsp_dat_q;
	assign rsp_tag   = rsp_tag_q;
	assign rsp_err   = rsp_err_q;
	assign rsp_rty   = rsp_rty_q;
	assign mst_busy  = cyc_q;

	// ----------------------------------------------------------------
	// Slave decode and terminators
	// ----------------------------------------------------------------
	assign s_sel = s_cyc_i & s_stb_i;
	assign s_hit = sbh_adr_hit(s_adr_i);
	assign s_idx = sbh_word_idx(s_adr_i);

	sbh_slv_term u_term (
		.sel_i   (s_sel),
		.bad_adr (~s_hit),
		.busy    (slv_busy),
		.ack     (s_ack_o),
		.err     (s_err_o),
		.rty     (s_rty_o)
	);

	// ----------------------------------------------------------------
	// Slave storage
	// ----------------------------------------------------------------
	sbh_lane_mux u_wr_lanes (
		.base   (mem_q[s_idx]),
		.fresh  (s_dat_i),
		.sel    (s_sel_i),
		.merged (wr_word)
	);

	sbh_lane_mux u_rd_lanes (
		.base   (DAT_RST),
		.fresh  (mem_q[s_idx]),
		.sel    (s_sel_i),
		.merged (rd_word)
	);

	for (genvar w = 0; w < MEM_DEPTH; w++) begin : g_word
		always_ff @(posedge clk_sys) begin
			if (!resetn) begin
				mem_q[w] <= DAT_RST;
			end else if (s_ack_o & s_we_i & (s_idx == IDX_W'(w))) begin
				mem_q[w] <= wr_word;
			end
		end
	end

	// Read data and its parity tag only ride along with a terminator;
	// unselected lanes read as zero.
	assign s_dat_o = (s_ack_o & ~s_we_i) ? rd_word : DAT_RST;
	assign s_tag_o = TAG_W'(^s_dat_o);

	// ----------------------------------------------------------------
	// Slave activity status
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			slv_wr_pulse_q <= 1'b0;
		end else begin
			slv_wr_pulse_q <= s_ack_o & s_we_i;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			xfer_cnt_q <= STAT_RST;
		end else if (s_ack_o) begin
			xfer_cnt_q <= xfer_cnt_q + 8'h01;
		end
	end

	// Wraps silently; software wanting totals must sample often.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			fault_cnt_q <= STAT_RST;
		end else if (s_err_o | s_rty_o) begin
			fault_cnt_q <= fault_cnt_q + 8'h01;
		end
	end

	assign slv_wr_pulse  = slv_wr_pulse_q;
	assign slv_xfer_cnt  = xfer_cnt_q;
	assign slv_fault_cnt = fault_cnt_q;

endmodule : sbh_bus_node

//--- sim/sbh_bus_props.sv
`timescale 1ns/100ps
module sbh_bus_props
	import sbh_pkg::*;
(
	input wire logic             clk_sys,
	input wire logic             resetn,
	input wire logic             m_cyc_o,
	input wire logic             m_stb_o,
	input wire logic             m_we_o,
	input wire logic             m_ack_i,
	input wire logic             m_err_i,
	input wire logic             m_rty_i,
	input wire logic [ADR_W-1:0] m_adr_o,
	input wire logic [DAT_W-1:0] m_dat_i,
	input wire logic             rsp_valid,
	input wire logic             rsp_err,
	input wire logic             rsp_rty,
	input wire logic [DAT_W-1:0] rsp_dat,
	input wire logic             s_cyc_i,
	input wire logic             s_stb_i,
	input wire logic [ADR_W-1:0] s_adr_i,
	input wire logic             s_ack_o,
	input wire logic             s_err_o,
	input wire logic             s_rty_o,
	input wire logic [DAT_W-1:0] s_dat_o
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------------
	// Master handshake steps
	// ----------------------------------------------------------------
	sequence s_wait;
		m_stb_o && !m_ack_i && !m_err_i && !m_rty_i;
	endsequence
	sequence s_ack;
		m_stb_o && m_ack_i && !m_err_i && !m_rty_i;
	endsequence
	sequence s_rty;
		m_stb_o && m_rty_i && !m_err_i;
	endsequence
	sequence s_off;
		!m_cyc_o && !m_stb_o;
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Reset check must not be switched off by reset itself
	rst_idle_a: assert property (disable iff (1'b0) !resetn |=> s_off)
		else $error("strobe or cycle high after reset edge");
	stb_in_cyc_a: assert property (m_stb_o |-> m_cyc_o)
		else $error("strobe without cycle");
	stb_hold_a: assert property (s_wait |=> m_stb_o && $stable(m_adr_o))
		else $error("strobe or address moved before terminator");
	term_drop_a: assert property (m_stb_o && (m_ack_i || m_err_i || m_rty_i) |=> !m_stb_o)
		else $error("strobe kept after terminator");
	ack_rsp_a: assert property (s_ack |=> rsp_valid && !rsp_err && !rsp_rty &&
		rsp_dat == ($past(m_we_o) ? '0 : $past(m_dat_i)))
		else $error("acknowledge not reported as normal end");
	err_rsp_a: assert property (m_stb_o && m_err_i |=> rsp_valid && rsp_err)
		else $error("error end not reported");
	rty_back_a: assert property (s_rty |=> s_off [*8])
		else $error("retry not backed off");
	slv_one_a: assert property ($onehot0({s_ack_o, s_err_o, s_rty_o}))
		else $error("two slave terminators together");
	slv_sel_a: assert property ((s_cyc_i && s_stb_i) == (s_ack_o || s_err_o || s_rty_o))
		else $error("slave terminator not following strobe");
	slv_err_a: assert property (s_cyc_i && s_stb_i && s_adr_i[ADR_W-1:HI_LSB] != '0 |-> s_err_o)
		else $error("out of range access not refused");
	dat_qual_a: assert property (!(s_ack_o || s_err_o || s_rty_o) |-> s_dat_o == '0)
		else $error("slave read data without terminator");
endmodule : sbh_bus_props

bind sbh_bus_node sbh_bus_props u_props (
	.clk_sys(clk_sys), .resetn(resetn), .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o), .m_we_o(m_we_o),
	.m_ack_i(m_ack_i), .m_err_i(m_err_i), .m_rty_i(m_rty_i), .m_adr_o(m_adr_o), .m_dat_i(m_dat_i),
	.rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rty(rsp_rty), .rsp_dat(rsp_dat),
	.s_cyc_i(s_cyc_i), .s_stb_i(s_stb_i), .s_adr_i(s_adr_i), .s_ack_o(s_ack_o),
	.s_err_o(s_err_o), .s_rty_o(s_rty_o), .s_dat_o(s_dat_o)
);

//--- sim/sbh_peer_slave.sv
`timescale 1ns/100ps
module sbh_peer_slave
	import sbh_pkg::*;
(
	input wire logic             clk_sys,
	input wire logic             resetn,
	input wire logic             cyc,
	input wire logic             stb,
	input wire logic [ADR_W-1:0] adr,
	input wire logic [1:0]       mode,
	input wire logic [3:0]       lat,
	output logic                 ack,
	output logic                 err,
	output logic                 rty,
	output logic     [DAT_W-1:0] dat,
	output logic     [TAG_W-1:0] tag
);
	// Interconnect watchdog limit in wait cycles; arbitrary bench choice
	localparam logic [3:0] DOG_LIM = 4'hC;

	logic [3:0] wait_q;
	logic       go;
	logic       dog;

	// ----------------------------------------------------------------
	// Wait states, then one terminator by mode; mode 3 acknowledges at once with no wait states
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!resetn || !stb || go) begin
			wait_q <= 4'h0;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end

	// Slave too slow to answer: the interconnect ends the cycle in error
	assign dog = cyc && stb && wait_q == DOG_LIM && lat > DOG_LIM;
	assign go  = cyc && stb && (wait_q == lat || dog);
	// Mode 3 holds acknowledge even with no strobe
	assign ack = mode == 2'h3 || (go && !dog && mode == 2'h0);
	assign err = go && (dog || mode == 2'h1);
	assign rty = go && !dog && mode == 2'h2;
	// Inverted pattern when not answering, never a stale copy
	assign dat = ack ? {24'hC35A96, adr} : ~{24'hC35A96, adr};
	assign tag = TAG_W'(^adr);
endmodule : sbh_peer_slave

//--- sim/sbh_bus_node_bench.sv
`timescale 1ns/100ps
module sbh_bus_node_bench
	import sbh_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn  = 1'b0;
	logic req_valid, req_ready, req_we, req_last, rsp_valid, rsp_err, rsp_rty, mst_busy;
	logic m_cyc_o, m_stb_o, m_we_o, m_ack_i, m_err_i, m_rty_i, slv_busy, slv_wr_pulse;
	logic s_cyc_i, s_stb_i, s_we_i, s_ack_o, s_err_o, s_rty_o;
	logic [ADR_W-1:0]  req_adr, m_adr_o, s_adr_i;
	logic [DAT_W-1:0]  req_dat, rsp_dat, m_dat_o, m_dat_i, s_dat_i, s_dat_o;
	logic [SEL_W-1:0]  req_sel, m_sel_o, s_sel_i;
	logic [TAG_W-1:0]  req_tag, rsp_tag, m_tag_o, m_tag_i, s_tag_o;
	logic [STAT_W-1:0] slv_xfer_cnt, slv_fault_cnt, xc, fc;
	logic [1:0]        pm_mode;
	logic [3:0]        pm_lat;
	logic [DAT_W+3:0]  e_m;
	logic [DAT_W+3:0]  exp_q [$];
	logic [DAT_W-1:0]  mem [MEM_DEPTH];
	logic              pw;
	int                fail_count = 0;
	int                num_checks = 0;

	always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

	sbh_bus_node u_dut (.*);
	sbh_peer_slave u_peer (.clk_sys(clk_sys), .resetn(resetn), .cyc(m_cyc_o), .stb(m_stb_o), .adr(m_adr_o),
		.mode(pm_mode), .lat(pm_lat), .ack(m_ack_i), .err(m_err_i), .rty(m_rty_i), .dat(m_dat_i), .tag(m_tag_i));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [DAT_W-1:0] e, input logic [DAT_W-1:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	// Expectation is {tag, compare data, err, rty, data}
	task automatic mreq(input logic we, input logic last, input logic [1:0] er);
		logic [ADR_W-1:0] a;
		logic [DAT_W-1:0] d;
		logic [SEL_W-1:0] s;
		logic [TAG_W-1:0] t;
		int n;
		a = ADR_W'($urandom);
		d = $urandom;
		s = SEL_W'($urandom);
		t = TAG_W'($urandom);
		req_valid <= 1'b1;
		req_we <= we;
		req_last <= last;
		req_adr <= a;
		req_dat <= d;
		req_sel <= s;
		req_tag <= t;
		exp_q.push_back({^a, er == 2'h0, er, we ? 32'h0 : {24'hC35A96, a}});
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 200);
		if (req_ready !== 1'b1) begin
			fail_count++;
			$display("mismatch req_ready expected 1 seen timeout");
		end
		req_valid <= 1'b0;
		@(negedge clk_sys);
		chk("m_adr_o", {24'h0, a}, {24'h0, m_adr_o});
		chk("m_dat_o", d, m_dat_o);
		chk("m_ctl", {24'h0, s, t, 2'h3, we}, {24'h0, m_sel_o, m_tag_o, m_stb_o, mst_busy, m_we_o});
		@(posedge clk_sys);
	endtask : mreq

	task automatic drain();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 500) begin
			@(posedge clk_sys);
			n++;
		end
		if (exp_q.size() != 0) begin
			fail_count++;
			$display("mismatch rsp_valid expected %0d more seen none", exp_q.size());
		end
		repeat (9) @(posedge clk_sys);
	endtask : drain

	// Held strobe across calls gives back-to-back slave transfers
	task automatic sacc(input logic we, input logic [ADR_W-1:0] a, input logic busy);
		logic [DAT_W-1:0] d, ed;
		logic [SEL_W-1:0] s;
		logic [IDX_W-1:0] ix;
		logic [2:0]       et;
		d = $urandom;
		s = SEL_W'($urandom);
		ix = a[HI_LSB-1:IDX_LSB];
		et = a[ADR_W-1:HI_LSB] != '0 ? 3'h2 : busy ? 3'h1 : 3'h4;
		ed = '0;
		for (int i = 0; i < SEL_W; i++) begin
			if (s[i] && !we && et == 3'h4) begin
				ed[LANE_W*i +: LANE_W] = mem[ix][LANE_W*i +: LANE_W];
			end
		end
		s_cyc_i <= 1'b1;
		s_stb_i <= 1'b1;
		s_we_i <= we;
		s_adr_i <= a;
		s_dat_i <= d;
		s_sel_i <= s;
		slv_busy <= busy;
		@(negedge clk_sys);
		chk("s_term", {29'h0, et}, {29'h0, s_ack_o, s_err_o, s_rty_o});
		chk("s_dat_o", ed, s_dat_o);
		chk("wr_pulse", {31'h0, pw}, {31'h0, slv_wr_pulse});
		chk("xfer_cnt", {24'h0, xc}, {24'h0, slv_xfer_cnt});
		chk("fault_cnt", {24'h0, fc}, {24'h0, slv_fault_cnt});
		chk("s_tag_o", {31'h0, ^ed}, {31'h0, s_tag_o});
		@(posedge clk_sys);
		pw = we && et == 3'h4;
		xc = xc + (et == 3'h4 ? 8'h01 : 8'h00);
		fc = fc + (et != 3'h4 ? 8'h01 : 8'h00);
		for (int i = 0; i < SEL_W; i++) begin
			if (s[i] && pw) begin
				mem[ix][LANE_W*i +: LANE_W] = d[LANE_W*i +: LANE_W];
			end
		end
	endtask : sacc

	// ----------------------------------------------------------------
	// Response checker
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (resetn && rsp_valid === 1'b1) begin
			e_m = exp_q.size() != 0 ? exp_q.pop_front() : '1;
			chk("rsp_err", {31'h0, e_m[DAT_W+1]}, {31'h0, rsp_err});
			chk("rsp_rty", {31'h0, e_m[DAT_W]}, {31'h0, rsp_rty});
			if (e_m[DAT_W+2]) begin
				chk("rsp_dat", e_m[DAT_W-1:0], rsp_dat);
				chk("rsp_tag", {31'h0, e_m[DAT_W+3]}, {31'h0, rsp_tag});
			end
		end
	end

	initial begin
		#(CLK_PERIOD_NS * 5000);
		fail_count++;
		$display("mismatch watchdog expected done seen hang");
		conclude();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(35));
		{req_valid, req_we, req_last, s_cyc_i, s_stb_i, s_we_i, slv_busy} = '0;
		{req_adr, req_dat, req_sel, req_tag, s_adr_i, s_dat_i, s_sel_i} = '0;
		pm_mode = 2'h0;
		pm_lat = 4'h2;
		repeat (20) @(posedge clk_sys);
		chk("rst_out", 32'h0, {29'h0, m_cyc_o, m_stb_o, rsp_valid});
		chk("rst_cnt", 32'h0, {16'h0, slv_xfer_cnt, slv_fault_cnt});
		resetn <= 1'b1;
		mreq(1'b0, 1'b1, 2'h0);
		chk("stb_early", 32'h1, {31'h0, m_stb_o});
		drain();
		for (int k = 0; k < 4; k++) begin
			pm_lat <= k[0] ? 4'h3 : 4'h0;
			mreq(k[1], 1'b1, 2'h0);
			drain();
		end
		pm_mode <= 2'h1;
		mreq(1'b1, 1'b1, 2'h2);
		drain();
		pm_mode <= 2'h2;
		mreq(1'b0, 1'b1, 2'h1);
		drain();
		pm_mode <= 2'h3;
		mreq(1'b0, 1'b0, 2'h0);
		drain();
		chk("cyc_hold", 32'h1, {31'h0, m_cyc_o});
		mreq(1'b1, 1'b0, 2'h0);
		mreq(1'b0, 1'b1, 2'h0);
		drain();
		pm_mode <= 2'h0;
		pm_lat <= 4'hF;
		mreq(1'b0, 1'b1, 2'h2);
		drain();
		mreq(1'b1, 1'b1, 2'h0);
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("mid_rst", 32'h0, {30'h0, m_cyc_o, m_stb_o});
		exp_q.delete();
		resetn <= 1'b1;
		xc = '0;
		fc = '0;
		pw = 1'b0;
		for (int i = 0; i < MEM_DEPTH; i++) begin
			mem[i] = '0;
		end
		@(posedge clk_sys);
		for (int i = 0; i < 40; i++) begin
			sacc(1'($urandom), ADR_W'($urandom) & (i % 5 == 4 ? 8'hFC : 8'h3C), i % 7 == 3);
		end
		s_cyc_i <= 1'b0;
		s_stb_i <= 1'b0;
		repeat (2) @(posedge clk_sys);
		conclude();
	end
endmodule : sbh_bus_node_bench
